// ### tps_seq.sv
// Touch panel converter sequencer with serial port and register slave
// What this block does
// - Serial clock alone steps shift and conversion
// - Sixteen serial clocks per conversion frame
// - Results in straight unsigned binary, 12 bits
// - Result MSB first, then eleven, then zeros
// - Tracking starts on fifth falling edge
// - Three clock periods of acquisition, then hold
// - Single-ended channel codes route inputs, drivers
// - Differential codes route inputs; 110 returns identity
// - Power bits both one keep drivers on
// - Fifteen-clock style keeps drivers on continuously for differential 12-bit conversions
// - Halted serial clock holds sequencer state
// - Command input ignored until start bit
// - Result output changes on falling edges
// - Resolution bit: 0 twelve bits, 1 eight
// - Result output high impedance while deselected
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module tps_seq
  import tps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic serial_conversion_clock,
  input wire logic din,
  input wire logic [RES_W-1:0] conv_code,
  output logic dout,
  output logic dout_oe,
  output logic busy,
  output logic busy_oe,
  output logic x_drv_on,
  output logic y_drv_on,
  output logic [1:0] mux_sel,
  output logic ref_diff,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    tps_frame_t fr;
    logic sclk_q;
    logic [2:0] bitn;
    logic [6:0] cmd;
    logic [3:0] fcnt;
    logic tracking;
    logic [14:0] sh;
    logic dout;
    logic dout_oe;
    logic busy;
    logic busy_oe;
    logic x_on;
    logic y_on;
    tps_mux_t mux;
    logic ref_diff;
    logic [3:0] conv_left;
    logic diff_hold;
    logic [1:0] pd;
    logic powered;
    logic push;
    logic [FIFO_W-1:0] push_data;
    logic halt;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } tps_state_t;

  tps_state_t s;
  tps_state_t next_s;
  tps_fifo_if fq ();
  logic rise;
  logic fall;
  logic active;
  tps_route_t trk_route;
  tps_route_t hold_route;
  logic [RES_W-1:0] code;

  // Map an offset to a register: read data and an error flag
  function automatic logic [32:0] reg_read(input logic [7:0] addr, input tps_state_t st,
                                            input logic fvalid, input logic fready,
                                            input logic [FIFO_W-1:0] fdata);
    logic [32:0] r;
    r = '0;
    case (addr)
      REG_CTRL: r[CTRL_HALT] = st.halt;
      REG_STATUS: r[15:0] = {2'b00, ~fready, fvalid, st.tracking, st.powered, st.pd, st.cmd[2],
                            st.cmd[3], st.cmd[6:4], st.busy, st.fr};
      REG_RESULT: r[31:0] = {fvalid, 15'h0000, {FIFO_W{fvalid}} & fdata}; // Empty buffer reads as zero
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction

  // Serial clock is sampled as a plain synchronous input; edges found here
  assign rise = serial_conversion_clock & ~s.sclk_q;
  assign fall = ~serial_conversion_clock & s.sclk_q;
  assign active = ~cs_n & ~s.halt;
  assign trk_route = tps_decode(s.cmd[3:1], 1'b1);
  assign hold_route = tps_decode(s.cmd[6:4], s.cmd[2]);

  // Result word: identity, conversion or zero for a bad code
  always_comb
  begin
    if (hold_route.ident)
      code = ID_CODE;
    else if (hold_route.valid)
      code = conv_code;
    else
      code = '0;
    if (s.cmd[3])
      code = {code[11:4], 4'h0};
  end

  // Results are popped by a read of the result register
  assign fq.in_valid = s.push;
  assign fq.in_data = s.push_data;
  assign fq.out_ready = s.arready & (s_axi_araddr == REG_RESULT);

  // Sequencer and register slave next state; sequencer moves only on serial edges, and returns to idle when inactive
  always_comb
  begin
    next_s = s;
    next_s.sclk_q = serial_conversion_clock;
    next_s.push = 1'b0;
    next_s.dout_oe = active;
    next_s.busy_oe = active;
    if (!active)
    begin
      next_s.fr = FR_IDLE;
      next_s.tracking = 1'b0;
      next_s.busy = 1'b0;
      next_s.bitn = '0;
      next_s.fcnt = '0;
    end
    else
    begin
      // Command bits on rising edges; full buffer stalls new frames
      if (rise)
      begin
        unique case (s.fr)
          FR_IDLE:
          begin
            if (din && fq.in_ready)
            begin
              next_s.fr = FR_CMD;
              next_s.bitn = '0;
              next_s.fcnt = '0;
            end
          end
          FR_CMD:
          begin
            next_s.cmd = {s.cmd[5:0], din};
            next_s.bitn = s.bitn + 3'h1;
            if (s.bitn == CMD_LAST)
              next_s.fr = FR_CONV;
          end
          FR_CONV: next_s.fr = FR_CONV;
          default: next_s.fr = FR_IDLE;
        endcase
      end
      // Output and timing on falling edges
      if (fall)
      begin
        next_s.dout = s.sh[14];
        next_s.sh = {s.sh[13:0], 1'b0};
        next_s.busy = 1'b0;
        if (s.conv_left != '0)
        begin
          next_s.conv_left = s.conv_left - 4'h1;
          // Ratiometric mode keeps the panel powered through conversion
          if (s.conv_left == 4'h1 && s.pd != PD_KEEP)
          begin
            next_s.x_on = 1'b0;
            next_s.y_on = 1'b0;
            next_s.diff_hold = 1'b0;
            next_s.powered = 1'b0;
          end
        end
        if (s.fr != FR_IDLE)
        begin
          next_s.fcnt = s.fcnt + 4'h1;
          // Later start on the same edge wins, so fifteen-clock differential 12-bit frames never drop drivers
          if (s.fcnt + 4'h1 == F_TRACK)
          begin
            next_s.tracking = 1'b1;
            next_s.powered = 1'b1;
            next_s.x_on = trk_route.x_on;
            next_s.y_on = trk_route.y_on;
            next_s.mux = trk_route.mux;
          end
          if (s.fcnt + 4'h1 == F_HOLD && s.fr == FR_CONV)
          begin
            next_s.tracking = 1'b0;
            next_s.fr = FR_IDLE;
            next_s.busy = 1'b1;
            next_s.sh = {code, 3'b000};
            next_s.push = 1'b1;
            next_s.push_data = {s.cmd[3], s.cmd[6:4], code};
            next_s.pd = s.cmd[1:0];
            next_s.ref_diff = ~s.cmd[2] & hold_route.valid;
            next_s.mux = hold_route.mux;
            next_s.conv_left = s.cmd[3] ? BITS_8 : BITS_12;
            next_s.diff_hold = ~s.cmd[2];
            if (!hold_route.valid || hold_route.ident)
            begin
              next_s.x_on = 1'b0;
              next_s.y_on = 1'b0;
            end
            else if (s.cmd[2] && s.cmd[1:0] != PD_KEEP)
            begin
              // Single-ended: switches open once acquisition is done
              next_s.x_on = 1'b0;
              next_s.y_on = 1'b0;
              next_s.powered = 1'b0;
            end
          end
        end
      end
    end

    // Write channel: address and data taken together
    if (!s.bvalid && !s.awready && s_axi_awvalid && s_axi_wvalid)
    begin
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (s.awready)
    begin
      next_s.awready = 1'b0;
      next_s.wready = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s_axi_awaddr == REG_CTRL)
      begin
        if (s_axi_wstrb[0])
          next_s.halt = s_axi_wdata[CTRL_HALT];
      end
      else if (s_axi_awaddr != REG_STATUS && s_axi_awaddr != REG_RESULT)
        next_s.bresp = RESP_SLVERR;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    // Read channel
    if (!s.rvalid && !s.arready && s_axi_arvalid)
      next_s.arready = 1'b1;
    if (s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      {next_s.rresp[1], next_s.rdata} = reg_read(s_axi_araddr, s, fq.out_valid, fq.in_ready, fq.out_data);
      next_s.rresp[0] = 1'b0;
    end
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
  end

  // Single state register; a halted serial clock leaves its sequencer fields untouched
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  tps_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .f(fq.store)
  );

  // Every output straight from the state register
  assign dout = s.dout;
  assign dout_oe = s.dout_oe;
  assign busy = s.busy;
  assign busy_oe = s.busy_oe;
  assign x_drv_on = s.x_on;
  assign y_drv_on = s.y_on;
  assign mux_sel = s.mux;
  assign ref_diff = s.ref_diff;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;

  // Checks on the sequencer behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_hiz_deselect;
    cs_n |=> !dout_oe && !busy_oe;
  endproperty
  a_hiz_deselect: assert property (p_hiz_deselect) else $error("output driven while deselected");

  property p_start_needed;
    (s.fr == FR_IDLE) && rise && !din |=> s.fr == FR_IDLE;
  endproperty
  a_start_needed: assert property (p_start_needed) else $error("frame began without start bit");

  property p_track_fifth;
    $rose(s.tracking) |-> $past(fall) && $past(s.fcnt) == 4'h4;
  endproperty
  a_track_fifth: assert property (p_track_fifth) else $error("tracking not on fifth falling edge");

  property p_hold_after_three;
    $fell(s.tracking) && $past(active) |-> busy && $past(s.fcnt) == 4'h7;
  endproperty
  a_hold_after_three: assert property (p_hold_after_three) else $error("acquisition not three periods");

  property p_dout_on_fall;
    $changed(dout) |-> $past(fall);
  endproperty
  a_dout_on_fall: assert property (p_dout_on_fall) else $error("result bit moved off a falling edge");

  property p_msb_first;
    fall && busy && active |=> dout == $past(s.push_data[RES_W-1]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("result bit order wrong");

  property p_invalid_off;
    fall && s.fr == FR_CONV && s.fcnt == 4'h7 && active && !hold_route.valid |=> !x_drv_on && !y_drv_on;
  endproperty
  a_invalid_off: assert property (p_invalid_off) else $error("drivers on for invalid code");

  property p_keep_on;
    x_drv_on && s.pd == PD_KEEP && !(fall && s.fr != FR_IDLE) |=> x_drv_on;
  endproperty
  a_keep_on: assert property (p_keep_on) else $error("drivers dropped in keep mode");

  property p_eight_bit;
    s.push && s.push_data[15] |-> s.push_data[3:0] == 4'h0;
  endproperty
  a_eight_bit: assert property (p_eight_bit) else $error("eight bit result has low bits");

  property p_push_on_hold;
    $rose(busy) |-> s.push;
  endproperty
  a_push_on_hold: assert property (p_push_on_hold) else $error("hold without result push");

  c_conversion: cover property ($rose(busy));
  c_ident: cover property (s.push && s.push_data[14:12] == 3'b110 && hold_route.ident);
  c_keep_mode: cover property (s.pd == PD_KEEP && $rose(s.tracking));
  c_result_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[RESULT_VALID]);
endmodule

// ### tps_pkg.sv
// Shared constants, types and decode for the touch panel sequencer
package tps_pkg;

  // Data path widths and buffer depth
  localparam int RES_W = 12;
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 16;

  // Serial clock rate and frame length in serial clock periods
  localparam int MCLK_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 500;
  localparam int FRAME_SCLKS = 16;
  localparam int MCLK_PER_SCLK = SCLK_PERIOD_NS / MCLK_PERIOD_NS;

  // Falling edges after the start bit: tracking opens, hold closes it
  localparam logic [3:0] F_TRACK = 4'h5;
  localparam logic [3:0] F_HOLD = 4'h8;
  localparam logic [2:0] CMD_LAST = 3'h6;
  localparam logic [3:0] BITS_12 = 4'hc;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [1:0] PD_KEEP = 2'b11;

  // Identity word; value is arbitrary
  localparam logic [11:0] ID_CODE = 12'h5a5;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam int CTRL_HALT = 0;
  localparam logic CTRL_HALT_RST = 1'b0;
  localparam int RESULT_VALID = 31;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Receiver states, Gray along idle, command, conversion
  typedef enum logic [1:0] {FR_IDLE = 2'b00, FR_CMD = 2'b01, FR_CONV = 2'b11} tps_frame_t;
  typedef enum logic [1:0] {MUX_XP = 2'b00, MUX_YP = 2'b01, MUX_AUX1 = 2'b10, MUX_AUX2 = 2'b11} tps_mux_t;

  typedef struct packed {
    logic valid;
    logic ident;
    logic x_on;
    logic y_on;
    tps_mux_t mux;
  } tps_route_t;

  // Channel code and reference mode to input and driver routing
  function automatic tps_route_t tps_decode(input logic [2:0] chan, input logic ser);
    tps_route_t r;
    r = '0;
    case ({chan, ser})
      4'b0011, 4'b0010:
      begin
        r.valid = 1'b1;
        r.mux = MUX_XP;
        r.y_on = 1'b1;
      end
      4'b1011, 4'b1010:
      begin
        r.valid = 1'b1;
        r.mux = MUX_YP;
        r.x_on = 1'b1;
      end
      4'b0101:
      begin
        r.valid = 1'b1;
        r.mux = MUX_AUX1;
      end
      4'b1101:
      begin
        r.valid = 1'b1;
        r.mux = MUX_AUX2;
      end
      4'b1100:
      begin
        r.valid = 1'b1;
        r.ident = 1'b1;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

endpackage

// ### tps_fifo_if.sv
// Carrier between the sequencer and its result buffer
`timescale 1ns/1ps
interface tps_fifo_if;
  import tps_pkg::*;
  logic [FIFO_W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [FIFO_W-1:0] out_data;
  logic out_valid;
  logic out_ready;
  modport user (output in_data, output in_valid, input in_ready, input out_data, input out_valid, output out_ready);
  modport store (input in_data, input in_valid, output in_ready, output out_data, output out_valid, input out_ready);
endinterface

// ### tps_fifo.sv
// Result buffer with valid and ready on both sides
`timescale 1ns/1ps
module tps_fifo
  import tps_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
)
(
  input wire logic mclk,
  input wire logic rst_n,
  tps_fifo_if.store f
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] count;
  } tps_fifo_state_t;

  tps_fifo_state_t s;
  tps_fifo_state_t next_s;
  logic [W-1:0] mem [D];
  logic do_push;
  logic do_pop;

  // Honest full and empty straight from the count
  assign f.in_ready = (s.count != (AW+1)'(D));
  assign f.out_valid = (s.count != '0);
  assign f.out_data = mem[s.rd];
  assign do_push = f.in_valid & f.in_ready;
  assign do_pop = f.out_valid & f.out_ready;

  // Pointer and count update
  always_comb
  begin
    next_s = s;
    if (do_push)
      next_s.wr = s.wr + 1'b1;
    if (do_pop)
      next_s.rd = s.rd + 1'b1;
    next_s.count = s.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // Storage carries no reset, only written data is ever read
  always_ff @(posedge mclk)
  begin
    if (do_push)
      mem[s.wr] <= f.in_data;
  end
endmodule

// ### tps_host_model.sv
// Host serial port model: chip select, serial clock, command, result capture
`timescale 1ns/1ps
module tps_host_model
(
  input wire logic mclk,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic busy,
  input wire logic x_drv_on,
  input wire logic y_drv_on,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  logic [23:0] rx;
  logic [1:0] drv5;
  logic [1:0] drv6;
  logic [2:0] bsy;

  // Deselected, serial clock still at time zero
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // n serial periods; extra low time before rise sat models a settling pause
  task automatic frame(input logic [7:0] cmd, input int n, input int sat, input int stall);
    for (int i = 1; i <= n; i++)
    begin
      din <= (i <= 8) ? cmd[8-i] : 1'b0;
      cs_n <= 1'b0;
      tick((i == sat) ? 12 + stall : 12);
      sclk <= 1'b1;
      rx <= {rx[22:0], dout_oe ? dout : 1'bz};
      if (i == 5)
        drv5 <= {x_drv_on, y_drv_on};
      if (i == 6)
        drv6 <= {x_drv_on, y_drv_on};
      if (i >= 8 && i <= 10)
        bsy <= {bsy[1:0], busy};
      tick(13);
      sclk <= 1'b0;
    end
  endtask

  // Deselect after the last falling edge; command line toggles while unused
  task automatic release_bus();
    tick(12);
    cs_n <= 1'b1;
    din <= ~din;
    tick(4);
  endtask
endmodule

// ### tps_seq_bench.sv
// Self-checking bench for the touch panel sequencer
`timescale 1ns/1ps
module tps_seq_bench
  import tps_pkg::*;
  ;
  logic mclk;
  logic rst_n = 1'b0;
  logic cs_n;
  logic sclk;
  logic din;
  logic [11:0] code = 12'h0;
  logic dout, dout_oe, busy, busy_oe, x_on, y_on, rdiff;
  logic [1:0] mux;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int drops = 0;
  logic watch = 1'b0;
  logic [31:0] d;
  logic [1:0] r;
  logic [9:0] e;
  logic md;
  logic [1:0] pd;
  logic [1:0] pv;
  logic [11:0] cv;
  logic [31:0] xr;
  logic [31:0] rq[$];
  logic [31:0] mq[$];
  // Channel, ser, drivers x y, mux, kind (0 conversion, 1 identity, 2 invalid)
  logic [9:0] tab [8] = '{10'b001_1_01_00_00, 10'b101_1_10_01_00, 10'b010_1_00_10_00, 10'b110_1_00_11_00,
    10'b001_0_01_00_00, 10'b101_0_10_01_00, 10'b110_0_00_00_01, 10'b011_1_00_00_10};

  tps_seq u_dut (.mclk, .rst_n, .cs_n, .serial_conversion_clock(sclk), .din, .conv_code(code), .dout, .dout_oe,
    .busy, .busy_oe, .x_drv_on(x_on), .y_drv_on(y_on), .mux_sel(mux), .ref_diff(rdiff), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  tps_host_model u_host (.mclk, .dout, .dout_oe, .busy, .x_drv_on(x_on), .y_drv_on(y_on), .cs_n, .sclk, .din);

  // 50 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cycle ceiling, and driver drops while a continuous run is watched
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (watch && x_on !== 1'b1)
      drops <= drops + 1;
    if (cyc == 30000)
    begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk({x_on, y_on, dout_oe}, 3'b000);
    axi_rd(REG_CTRL);
    chk(d[CTRL_HALT], CTRL_HALT_RST);
    u_host.frame(8'h00, 3, 0, 0);
    pv = 2'b00;
    for (int i = 0; i < 8; i++)
    begin
      e = tab[i];
      md = (i == 2 || i == 3);
      pd = {2{i[0]}};
      cv = 12'hc35 ^ {4{i[2:0]}};
      code <= cv;
      u_host.frame({1'b1, e[9:7], md, e[6], pd}, 24, 7, (i == 0) ? 400 : 0);
      chk(u_host.drv5, pv);
      chk(u_host.drv6, e[5:4]);
      chk(u_host.bsy, 3'b010);
      xr = (e[1:0] == 2'b01) ? {ID_CODE, 3'b000} : (e[1:0] == 2'b10) ? 15'h0 : md ? {cv[11:4], 7'h0} : {cv, 3'b000};
      chk(u_host.rx[14:0], xr);
      chk({dout_oe, busy_oe}, 2'b11);
      u_host.release_bus();
      chk({dout_oe, busy_oe}, 2'b00);
      pv = (pd == 2'b11) ? e[5:4] : 2'b00;
      chk({x_on, y_on}, pv);
      if (e[1:0] == 2'b00)
        chk({mux, rdiff}, {e[3:2], ~e[6]});
      // Identity word, zero for a bad code, low nibble cleared in eight-bit mode
      xr = (e[1:0] == 2'b01) ? ID_CODE : (e[1:0] == 2'b10) ? 12'h0 : md ? {cv[11:4], 4'h0} : cv;
      rq.push_back({1'b1, 15'h0, md, e[9:7], xr[11:0]});
      mq.push_back(32'hffff_ffff);
    end
    // Halted port ignores a frame and floats the result line
    axi_wr(REG_CTRL, 32'h1);
    chk(r, RESP_OKAY);
    axi_rd(REG_CTRL);
    chk(d[CTRL_HALT], 1'b1);
    u_host.frame(8'h94, 12, 0, 0);
    chk({dout_oe, busy_oe}, 2'b00);
    u_host.release_bus();
    axi_wr(REG_CTRL, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      axi_rd(REG_RESULT);
      if (i < 8)
        chk(d & mq[i], rq[i] & mq[i]);
      else
        chk(d[31], 1'b0);
    end
    axi_rd(8'h0c);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    axi_wr(8'h10, 32'h1);
    chk(r, RESP_SLVERR);
    // Fifteen-clock cadence keeps the X drivers up across frames
    for (int i = 0; i < 4; i++)
    begin
      u_host.frame(8'hd0, 15, 0, 0);
      watch <= (i < 3);
    end
    chk(drops, 0);
    u_host.frame(8'hd0, 24, 0, 0);
    u_host.release_bus();
    chk(x_on, 1'b0);
    repeat (8) axi_rd(REG_RESULT);
    // Fill the buffer until a start is refused, then drain with gaps
    for (int i = 0; i < 17; i++)
    begin
      code <= i[11:0];
      u_host.frame(8'h94, 9, 0, 0);
    end
    u_host.release_bus();
    axi_rd(REG_STATUS);
    chk({d[13], d[1:0]}, 3'b100);
    for (int i = 0; i < 17; i++)
    begin
      repeat (5) @(posedge mclk);
      axi_rd(REG_RESULT);
      chk(d, (i < 16) ? 32'h8000_1000 | i : 32'h0);
    end
    end_of_test();
  end
endmodule
